// ---- timer_bank_regs.vh ----
// Register map and field constants of the five-channel timer bank
`ifndef TIMER_BANK_REGS_VH
`define TIMER_BANK_REGS_VH

// Printed offsets are not all multiples of four: these are register indices
`define T1_COMPARE_A 20'h48188
`define T1_COMPARE_B 20'h4818A
`define T1_COUNT 20'h4818C
`define T1_CONTROL 20'h4818E
`define T2_COMPARE_A 20'h48190
`define T2_COMPARE_B 20'h48192
`define T2_COUNT 20'h48194
`define T2_CONTROL 20'h48196
`define T3_COMPARE_A 20'h48198
`define T3_COMPARE_B 20'h4819A
`define T3_COUNT 20'h4819C
`define T3_CONTROL 20'h4819E
`define T4_COMPARE_A 20'h481A0
`define T4_COMPARE_B 20'h481A2
`define T4_COUNT 20'h481A4
`define T4_CONTROL 20'h481A6
`define T5_COMPARE_A 20'h481A8
`define T5_COMPARE_B 20'h481AA
`define T5_COUNT 20'h481AC
`define T5_CONTROL 20'h481AE

// Channel stride in index units and the byte-address width
`define CHANNEL_STRIDE 20'h00008
`define ADDR_WIDTH 22

// Register slot within a channel (index low bits [2:1])
`define SLOT_COMPARE_A 2'h0
`define SLOT_COMPARE_B 2'h1
`define SLOT_COUNT 2'h2
`define SLOT_CONTROL 2'h3

// Control fields
`define CTRL_FINE 6
`define CTRL_SHADOW 5
`define CTRL_INVERT 4
`define CTRL_EXT_CLK 3
`define CTRL_CLK_OUT 2
`define CTRL_CLEAR 1
`define CTRL_RUN 0
`define CTRL_RESET 7'h00
`define CTRL_RW_MASK 8'h7D

`endif

// ---- timer_channel.v ----
// One 16-bit programmable timer channel
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module timer_channel (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // Register writes
    input wire i_wr_a,
    input wire i_wr_b,
    input wire i_wr_ctrl,
    input wire [15:0] i_wdata,
    // Count source
    input wire i_ext_clk,
    // State
    output wire [15:0] o_compare_a,
    output wire [15:0] o_compare_b,
    output wire [15:0] o_count,
    output wire [6:0] o_ctrl,
    output reg o_timer_out
);
`include "timer_bank_regs.vh"

    reg [15:0] active_a;
    reg [15:0] active_b;
    reg [15:0] shadow_a;
    reg [15:0] shadow_b;
    reg [15:0] count;
    reg [6:0] ctrl;
    reg ext_prev;
    reg timer_level;
    reg half_step;
    reg next_timer_out;

    wire shadow_on = ctrl[`CTRL_SHADOW];
    wire soft_clear = i_wr_ctrl && i_wdata[`CTRL_CLEAR];
    wire ext_edge = i_ext_clk && !ext_prev;
    wire tick = ctrl[`CTRL_RUN] && (ctrl[`CTRL_EXT_CLK] ? ext_edge : 1'b1);
    wire match_a = tick && (count == active_a);
    wire match_b = tick && (count == active_b);
    wire reload = soft_clear || match_b;

    assign o_compare_a = shadow_on ? shadow_a : active_a;
    assign o_compare_b = shadow_on ? shadow_b : active_b;
    assign o_count = count;
    assign o_ctrl = ctrl;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl <= `CTRL_RESET;
        end else if (i_wr_ctrl) begin
            ctrl <= i_wdata[6:0] & 7'h7D;
        end
    end

    // ------------------------------------------------------------
    // Compare values, shadow and counter
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (i_wr_a && shadow_on) begin
            shadow_a <= i_wdata;
        end
        if (i_wr_b && shadow_on) begin
            shadow_b <= i_wdata;
        end
        if (i_wr_a && !shadow_on) begin
            active_a <= i_wdata;
        end else if (reload && shadow_on) begin
            active_a <= shadow_a;
        end
        if (i_wr_b && !shadow_on) begin
            active_b <= i_wdata;
        end else if (reload && shadow_on) begin
            active_b <= shadow_b;
        end
        if (reload) begin
            count <= 16'h0000;
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Output waveform
    // ------------------------------------------------------------
    always @* begin
        if (!ctrl[`CTRL_CLK_OUT]) begin
            next_timer_out = ctrl[`CTRL_INVERT];
        end else if (ctrl[`CTRL_FINE] && half_step) begin
            next_timer_out = (!timer_level) ^ ctrl[`CTRL_INVERT];
        end else begin
            next_timer_out = timer_level ^ ctrl[`CTRL_INVERT];
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_prev <= 1'b0;
            timer_level <= 1'b0;
            half_step <= 1'b0;
            o_timer_out <= 1'b0;
        end else begin
            ext_prev <= i_ext_clk;
            if (reload) begin
                timer_level <= 1'b0;
            end else if (match_a) begin
                timer_level <= 1'b1;
            end
            // Fine mode: delay the A edge by one clock cycle when active compare B is odd
            half_step <= match_a && ctrl[`CTRL_FINE] && active_b[0];
            o_timer_out <= next_timer_out;
        end
    end
endmodule

// ---- timer_bank.v ----
// APB register bank for five 16-bit programmable timers
`timescale 1ns/10ps
module timer_bank (
    // Clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [21:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // Timer pins
    input wire [4:0] i_ext_count_clk,
    output reg [4:0] o_timer_clock_output
);
`include "timer_bank_regs.vh"

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [19:0] index = i_paddr[21:2];
    wire [19:0] rel = index - `T1_COMPARE_A;
    wire aligned = (i_paddr[1:0] == 2'h0) && (rel[0] == 1'b0);
    wire mapped = aligned && (index >= `T1_COMPARE_A) && (index <= `T5_CONTROL);
    wire [2:0] chan = rel[5:3];
    wire [1:0] slot = rel[2:1];
    wire setup = i_psel && !i_penable;
    wire wr_go = setup && i_pwrite && mapped;

    // Pin synchronisers
    reg [4:0] ext_meta;
    reg [4:0] ext_sync;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_meta <= 5'h00;
            ext_sync <= 5'h00;
        end else begin
            ext_meta <= i_ext_count_clk;
            ext_sync <= ext_meta;
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    wire [79:0] cmp_a;
    wire [79:0] cmp_b;
    wire [79:0] cnt;
    wire [34:0] ctl;
    wire [4:0] tout;
    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1) begin : ch
            wire sel = wr_go && (chan == g);
            timer_channel u_chan (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_wr_a(sel && (slot == `SLOT_COMPARE_A)),
                .i_wr_b(sel && (slot == `SLOT_COMPARE_B)),
                .i_wr_ctrl(sel && (slot == `SLOT_CONTROL)),
                .i_wdata(i_pwdata[15:0]),
                .i_ext_clk(ext_sync[g]),
                .o_compare_a(cmp_a[g*16 +: 16]),
                .o_compare_b(cmp_b[g*16 +: 16]),
                .o_count(cnt[g*16 +: 16]),
                .o_ctrl(ctl[g*7 +: 7]),
                .o_timer_out(tout[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read mux and APB response
    // ------------------------------------------------------------
    reg [31:0] next_prdata;
    always @* begin
        next_prdata = 32'h00000000;
        case (slot)
            `SLOT_COMPARE_A: next_prdata[15:0] = cmp_a[chan*16 +: 16];
            `SLOT_COMPARE_B: next_prdata[15:0] = cmp_b[chan*16 +: 16];
            `SLOT_COUNT: next_prdata[15:0] = cnt[chan*16 +: 16];
            default: next_prdata[6:0] = ctl[chan*7 +: 7] & 7'h7D;
        endcase
        if (!mapped || i_pwrite) begin
            next_prdata = 32'h00000000;
        end
    end

    // One-cycle access phase: answer registered during setup
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h00000000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_timer_clock_output <= 5'h00;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup && (!mapped || (i_pwrite && slot == `SLOT_COUNT));
            if (setup) begin
                o_prdata <= next_prdata;
            end
            o_timer_clock_output <= tout;
        end
    end
endmodule

// ---- timer_bank_properties.sv ----
// Port assertions for the timer bank
`timescale 1ns/10ps
module timer_bank_properties (
    // Clock and APB
    input wire i_clk,
    input wire i_rst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [21:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire o_pready,
    input wire o_pslverr,
    // Timer pins
    input wire [4:0] i_ext_count_clk,
    input wire [4:0] o_timer_clock_output
);
    wire map = i_paddr >= 22'h120620 && i_paddr <= 22'h1206B8 && i_paddr[2:0] == 3'h0;
    wire bad = !map || (i_pwrite && i_paddr[4:3] == 2'h2);
    wire rd = i_psel && i_penable && o_pready && !i_pwrite;
    // ----------------
    // Assertions
    // ----------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_setup; i_psel && !i_penable; endsequence
    sequence s_pulse; o_pready ##1 !o_pready; endsequence
    property p_answer; s_setup |=> s_pulse; endproperty
    property p_refuse; s_setup ##0 bad |=> o_pslverr; endproperty
    property p_accept; s_setup ##0 !bad |=> !o_pslverr; endproperty
    property p_errpair; o_pslverr |-> o_pready; endproperty
    property p_ctrl; rd && map && i_paddr[4:3] == 2'h3 |-> o_prdata[31:7] == 25'h0
        && !o_prdata[1]; endproperty
    property p_upper; rd |-> o_prdata[31:16] == 16'h0000; endproperty
    property p_hole; rd && !map |-> o_prdata == 32'h0; endproperty
    property p_rstout; $rose(i_rst_n) |-> o_timer_clock_output == 5'h00; endproperty
    property p_hold; o_pready ##1 !i_psel |-> $stable(o_prdata); endproperty
    a_answer: assert property (p_answer)
        else $error("ready not one cycle after setup");
    a_refuse: assert property (p_refuse)
        else $error("missing error response");
    a_accept: assert property (p_accept)
        else $error("spurious error response");
    a_errpair: assert property (p_errpair)
        else $error("error without ready");
    a_ctrl: assert property (p_ctrl)
        else $error("control spare or clear bit reads one");
    a_upper: assert property (p_upper)
        else $error("upper read bits not zero");
    a_hole: assert property (p_hole)
        else $error("unmapped read not zero");
    a_rstout: assert property (p_rstout)
        else $error("timer output not off after reset");
    a_hold: assert property (p_hold)
        else $error("read data changed after access");
endmodule

bind timer_bank timer_bank_properties timer_bank_properties_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_ext_count_clk(i_ext_count_clk), .o_timer_clock_output(o_timer_clock_output));

// ---- tb_top.sv ----
// Self-checking bench for the timer bank
`timescale 1ns/10ps
module tb_top;
    logic i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [21:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata;
    logic o_pready, o_pslverr;
    logic [4:0] i_ext_count_clk = 0, o_timer_clock_output;
    logic [33:0] q[$];
    logic [33:0] e;
    logic [15:0] va, vb;
    int fail_count = 0, total_checks = 0;
    always #12.5 i_clk = ~i_clk;
    timer_bank timer_bank_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_ext_count_clk(i_ext_count_clk), .o_timer_clock_output(o_timer_clock_output));
    // ----------------
    // Helpers
    // ----------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    function automatic logic [21:0] ad(input int c, input int s);
        return 22'h120620 + 22'(c * 32 + s * 8);
    endfunction
    // Read expects d; write drives d
    task apb(input logic w, input logic [21:0] a, input logic [31:0] d, input logic ee);
        int n;
        q.push_back({!w, ee, d});
        i_psel <= 1;
        i_penable <= 0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (o_pready !== 1'b1) begin
            fail_count++;
            results();
        end
        i_psel <= 0;
        i_penable <= 0;
        @(posedge i_clk);
    endtask
    task pulse(input int k);
        repeat (k) begin
            i_ext_count_clk <= 5'h1F;
            repeat (4) @(posedge i_clk);
            i_ext_count_clk <= 5'h00;
            repeat (4) @(posedge i_clk);
        end
    endtask
    always @(posedge i_clk) begin
        if (o_pready === 1'b1) begin
            if (q.size() == 0) chk(1, 0);
            else begin
                e = q.pop_front();
                chk(o_pslverr, e[32]);
                if (e[33]) chk(o_prdata, e[31:0]);
            end
        end
    end
    initial begin
        void'($urandom(24));
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1;
        @(posedge i_clk);
        for (int c = 0; c < 5; c++) begin
            va = 16'($urandom);
            vb = 16'($urandom);
            apb(0, ad(c, 3), 0, 0);
            apb(1, ad(c, 0), va, 0);
            apb(1, ad(c, 1), vb, 0);
            apb(0, ad(c, 0), va, 0);
            apb(0, ad(c, 1), vb, 0);
            apb(1, ad(c, 3), 32'hFF, 0);
            apb(0, ad(c, 3), 32'h7D, 0);
            apb(1, ad(c, 2), 0, 1);
        end
        apb(1, ad(0, 3), 32'h02, 0);
        apb(0, ad(0, 2), 0, 0);
        apb(1, ad(0, 0), 1, 0);
        apb(1, ad(0, 1), 100, 0);
        apb(1, ad(0, 3), 32'h0F, 0);
        apb(0, ad(0, 2), 0, 0);
        pulse(3);
        apb(0, ad(0, 2), 3, 0);
        chk(o_timer_clock_output[0], 1);
        apb(1, ad(0, 3), 32'h1D, 0);
        repeat (2) @(posedge i_clk);
        chk(o_timer_clock_output[0], 0);
        apb(1, ad(0, 3), 32'h18, 0);
        repeat (2) @(posedge i_clk);
        chk(o_timer_clock_output[0], 1);
        apb(1, ad(0, 3), 32'h20, 0);
        apb(1, ad(0, 0), 7, 0);
        apb(0, ad(0, 0), 7, 0);
        apb(1, ad(0, 3), 32'h22, 0);
        apb(1, ad(0, 3), 32'h00, 0);
        apb(0, ad(0, 0), 7, 0);
        apb(0, 22'h120624, 0, 1);
        apb(1, 22'h100000, 5, 1);
        results();
    end
endmodule
